/* File: logic/tseg_pkg.sv */
// How it works
// RL1 - writing one to force_update_bit reinitialises the counter and makes an update event
// RL2 - force_update_bit self-clears in hardware after it acts
// RL3 - every update event clears the prescaler count, prescaler factor kept
// RL4 - forced update while counting down loads the counter with reload_value
// RL5 - forced update while counting up or center-aligned clears the counter
// RL6 - channel 1 output mode: force sets ch1_event_flag, raises enabled irq and dma
// RL7 - channel 1 input mode: force copies counter into ch1_capture_value, sets flag
// RL8 - forced capture with ch1_event_flag already set also sets repeat-capture flag
// RL9 - bits 2 to 4 do the same for channels 2 to 4
// RL10 - force_trigger_bit makes a trigger event, zero does nothing, bit self-clears
// RL11 - forced update sets update_event_flag until software writes zero to it
// RL12 - trigger event sets trigger_event_flag until software clears it
// RL13 - software_event_trigger reads as zero, reserved bits ignored on write
package tseg_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_EVENT = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h0c;
  localparam logic [7:0] OFS_RELOAD = 8'h2c;
  localparam logic [7:0] OFS_PSC = 8'h28;
  localparam logic [7:0] OFS_CNT = 8'h24;
  localparam logic [7:0] OFS_CAP1 = 8'h34;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_UPDATE = 0;
  localparam int BIT_CH_LO = 1;
  localparam int BIT_TRIGGER = 6;
  localparam int BIT_RPT_LO = 9;
  localparam int BIT_DOWN = 4;
  localparam int BIT_CMS_LO = 5;
  localparam int BIT_CH_INPUT_LO = 8;
  localparam int BIT_DMA_LO = 9;
  localparam int NUM_CH = 4;
  // ----------------------------------------
  // reset values and responses
  // ----------------------------------------
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [15:0] RST_RELOAD = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [15:0] STATUS_MASK = 16'h1e5f;
endpackage

/* File: logic/tseg_timer.sv */
`timescale 1ns/1ps
module tseg_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic [3:0] dma_req,
  output logic update_pulse,
  output logic trigger_pulse
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam int NUM_CH_L = tseg_pkg::NUM_CH;

  // bus channel holding registers
  logic aw_ff;
  logic w_ff;
  logic b_ff;
  logic r_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [31:0] rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff;
  logic [1:0] rresp_ff;
  // software-visible settings
  logic [15:0] ctrl_ff;
  logic [15:0] ien_ff;
  logic [15:0] reload_ff;
  logic [15:0] psc_ff;
  // counting engine
  logic [15:0] cnt_ff;
  logic [15:0] pscnt_ff;
  logic [15:0] cap_ff [NUM_CH_L];
  // sticky status flags, one register per concern
  logic upd_flag_ff;
  logic trg_flag_ff;
  logic [3:0] ch_flag_ff;
  logic [3:0] rpt_flag_ff;
  logic [15:0] status_word;
  // registered request and event pulses
  logic [3:0] dma_ff;
  logic upd_ff;
  logic trg_ff;

  // decode of the write that completes this cycle
  logic wr_go;
  logic [15:0] wval;
  logic force_update;
  logic force_trigger;
  logic [3:0] force_ch;
  // mode bits taken from the control register
  logic [3:0] ch_input;
  logic counting_down;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // merges byte strobes into the low half word
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // true when a write to the given offset completes this cycle
  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_go && (awaddr_ff == ofs);
  endfunction

  // byte offset of a channel's capture register
  function automatic logic [7:0] cap_ofs(input int idx);
    cap_ofs = tseg_pkg::OFS_CAP1 + 8'(4 * idx);
  endfunction

  // true when software writes zero to this status bit, its byte lane enabled
  function automatic logic clr_bit(input int pos);
    clr_bit = hit(tseg_pkg::OFS_STATUS) && wstrb_ff[pos / 8] && !wval[pos];
  endfunction

  // true for an aligned offset that names a register of this block
  function automatic logic reg_mapped(input logic [7:0] ofs);
    reg_mapped = 1'b0;
    for (int i = 0; i < NUM_CH_L; i++) begin
      if (ofs == cap_ofs(i)) reg_mapped = 1'b1;
    end
    case (ofs)
      tseg_pkg::OFS_CTRL, tseg_pkg::OFS_IRQ_EN, tseg_pkg::OFS_STATUS, tseg_pkg::OFS_EVENT,
      tseg_pkg::OFS_CNT, tseg_pkg::OFS_PSC, tseg_pkg::OFS_RELOAD: reg_mapped = 1'b1;
      default: ;
    endcase
  endfunction

  // value that a read of the given offset returns, event register included
  function automatic logic [15:0] read_word(input logic [7:0] ofs);
    read_word = 16'h0000;
    case (ofs)
      tseg_pkg::OFS_CTRL: read_word = ctrl_ff;
      tseg_pkg::OFS_IRQ_EN: read_word = ien_ff;
      tseg_pkg::OFS_STATUS: read_word = status_word & tseg_pkg::STATUS_MASK;
      tseg_pkg::OFS_EVENT: read_word = 16'h0000; // [RL13]
      tseg_pkg::OFS_CNT: read_word = cnt_ff;
      tseg_pkg::OFS_PSC: read_word = psc_ff;
      tseg_pkg::OFS_RELOAD: read_word = reload_ff;
      default: read_word = 16'h0000;
    endcase
    for (int i = 0; i < NUM_CH_L; i++) begin
      if (ofs == cap_ofs(i)) read_word = cap_ff[i];
    end
  endfunction

  // ----------------------------------------
  // write channels, taken in either order
  // ----------------------------------------
  assign s_axi_awready = !aw_ff && !b_ff;
  assign s_axi_wready = !w_ff && !b_ff;
  assign wr_go = aw_ff && w_ff && !b_ff;
  assign wval = merge16(16'h0000, wdata_ff, wstrb_ff);

  // address and data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_go) begin
        w_ff <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      b_ff <= 1'b0;
      bresp_ff <= tseg_pkg::RESP_OKAY;
    end else if (wr_go) begin
      b_ff <= 1'b1;
      bresp_ff <= reg_mapped(awaddr_ff) ? tseg_pkg::RESP_OKAY : tseg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      b_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = b_ff;
  assign s_axi_bresp = bresp_ff;

  // ----------------------------------------
  // forced events, one-cycle pulses (bits self-clear)
  // ----------------------------------------
  assign force_update = hit(tseg_pkg::OFS_EVENT) && wval[tseg_pkg::BIT_UPDATE];   // [RL1] [RL2]
  assign force_trigger = hit(tseg_pkg::OFS_EVENT) && wval[tseg_pkg::BIT_TRIGGER]; // [RL10]
  assign force_ch = hit(tseg_pkg::OFS_EVENT) ? wval[tseg_pkg::BIT_CH_LO +: 4] : 4'h0; // [RL9]
  assign ch_input = ctrl_ff[tseg_pkg::BIT_CH_INPUT_LO +: 4];
  assign counting_down = ctrl_ff[tseg_pkg::BIT_DOWN] &&
                         (ctrl_ff[tseg_pkg::BIT_CMS_LO +: 2] == 2'b00);

  // ----------------------------------------
  // settings and counting engine
  // ----------------------------------------
  // control, enables, reload and prescaler factor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= tseg_pkg::RST_REG16;
      ien_ff <= tseg_pkg::RST_REG16;
      reload_ff <= tseg_pkg::RST_RELOAD;
      psc_ff <= tseg_pkg::RST_REG16;
    end else begin
      if (hit(tseg_pkg::OFS_CTRL)) ctrl_ff <= merge16(ctrl_ff, wdata_ff, wstrb_ff);
      if (hit(tseg_pkg::OFS_IRQ_EN)) ien_ff <= merge16(ien_ff, wdata_ff, wstrb_ff);
      if (hit(tseg_pkg::OFS_RELOAD)) reload_ff <= merge16(reload_ff, wdata_ff, wstrb_ff);
      if (hit(tseg_pkg::OFS_PSC)) psc_ff <= merge16(psc_ff, wdata_ff, wstrb_ff); // [RL3]
    end
  end

  // counter and prescaler count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= tseg_pkg::RST_REG16;
      pscnt_ff <= tseg_pkg::RST_REG16;
    end else if (force_update) begin
      pscnt_ff <= 16'h0000; // [RL3]
      cnt_ff <= counting_down ? reload_ff : 16'h0000; // [RL4] [RL5]
    end else if (hit(tseg_pkg::OFS_CNT)) begin
      cnt_ff <= merge16(cnt_ff, wdata_ff, wstrb_ff);
    end else if (pscnt_ff >= psc_ff) begin
      pscnt_ff <= 16'h0000;
      if (ctrl_ff[0]) begin
        cnt_ff <= counting_down ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001;
      end
    end else begin
      pscnt_ff <= pscnt_ff + 16'h0001;
    end
  end

  // capture registers for input-mode channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_CH_L; i++) cap_ff[i] <= tseg_pkg::RST_REG16;
    end else begin
      for (int i = 0; i < NUM_CH_L; i++) begin
        if (force_ch[i] && ch_input[i]) begin
          cap_ff[i] <= cnt_ff; // [RL7] [RL9]
        end else if (hit(cap_ofs(i)) && !ch_input[i]) begin
          cap_ff[i] <= merge16(cap_ff[i], wdata_ff, wstrb_ff);
        end
      end
    end
  end

  // ----------------------------------------
  // status flags: write zero clears, set wins
  // ----------------------------------------
  // a set and a software clear in one cycle: the set wins, so no event is lost

  // update flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upd_flag_ff <= 1'b0;
    end else if (force_update) begin
      upd_flag_ff <= 1'b1; // [RL11]
    end else if (clr_bit(tseg_pkg::BIT_UPDATE)) begin
      upd_flag_ff <= 1'b0;
    end
  end

  // trigger flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trg_flag_ff <= 1'b0;
    end else if (force_trigger) begin
      trg_flag_ff <= 1'b1; // [RL12]
    end else if (clr_bit(tseg_pkg::BIT_TRIGGER)) begin
      trg_flag_ff <= 1'b0;
    end
  end

  // channel event flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch_flag_ff <= 4'h0;
    end else begin
      for (int i = 0; i < NUM_CH_L; i++) begin
        if (force_ch[i]) begin
          ch_flag_ff[i] <= 1'b1; // [RL6] [RL7] [RL9]
        end else if (clr_bit(tseg_pkg::BIT_CH_LO + i)) begin
          ch_flag_ff[i] <= 1'b0;
        end
      end
    end
  end

  // repeat-capture flags: a forced capture over a flag that still stands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rpt_flag_ff <= 4'h0;
    end else begin
      for (int i = 0; i < NUM_CH_L; i++) begin
        if (force_ch[i] && ch_input[i] && ch_flag_ff[i]) begin
          rpt_flag_ff[i] <= 1'b1; // [RL8]
        end else if (clr_bit(tseg_pkg::BIT_RPT_LO + i)) begin
          rpt_flag_ff[i] <= 1'b0;
        end
      end
    end
  end

  // status word as software sees it, reserved bits zero
  always_comb begin
    status_word = 16'h0000;
    status_word[tseg_pkg::BIT_UPDATE] = upd_flag_ff;
    status_word[tseg_pkg::BIT_CH_LO +: 4] = ch_flag_ff;
    status_word[tseg_pkg::BIT_TRIGGER] = trg_flag_ff;
    status_word[tseg_pkg::BIT_RPT_LO +: 4] = rpt_flag_ff;
  end

  // ----------------------------------------
  // requests, pulses and interrupt
  // ----------------------------------------
  // dma requests and event pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_ff <= 4'h0;
      upd_ff <= 1'b0;
      trg_ff <= 1'b0;
    end else begin
      dma_ff <= force_ch & ien_ff[tseg_pkg::BIT_DMA_LO +: 4]; // [RL6] [RL9]
      upd_ff <= force_update; // [RL1]
      trg_ff <= force_trigger; // [RL10]
    end
  end
  assign dma_req = dma_ff;
  assign update_pulse = upd_ff;
  assign trigger_pulse = trg_ff;
  // interrupt when an enabled update, channel or trigger flag stands; repeat-capture flags never raise it
  assign irq = |(status_word & ien_ff & 16'h005f); // [RL6]

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= tseg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      r_ff <= 1'b1;
      // unmapped offsets read zero and answer with an error
      rdata_ff <= {16'h0000, read_word(s_axi_araddr)};
      rresp_ff <= reg_mapped(s_axi_araddr) ? tseg_pkg::RESP_OKAY : tseg_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      r_ff <= 1'b0;
    end
  end
  assign s_axi_arready = !r_ff;
  assign s_axi_rvalid = r_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule // tseg_timer

/* File: verif/tseg_checker.sv */
`timescale 1ns/1ps
module tseg_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire logic [3:0] dma_req,
  input wire logic update_pulse,
  input wire logic trigger_pulse
);
  // event register write taken on both channels at one edge
  logic ev_wr;
  assign ev_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
                 (s_axi_awaddr == tseg_pkg::OFS_EVENT) && s_axi_wstrb[0];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_update_on_write: assert property (ev_wr && s_axi_wdata[0] |-> ##2 update_pulse)
    else $error("update pulse missing after forced update");
  a_update_one_cycle: assert property (update_pulse |=> !update_pulse)
    else $error("update pulse longer than one cycle");
  a_update_cause: assert property (update_pulse |-> $past(ev_wr && s_axi_wdata[0], 2))
    else $error("update pulse without a forcing write");
  a_trigger_on_write: assert property (ev_wr && s_axi_wdata[6] |-> ##2 trigger_pulse)
    else $error("trigger pulse missing after forced trigger");
  a_trigger_one_cycle: assert property (trigger_pulse |=> !trigger_pulse)
    else $error("trigger pulse longer than one cycle");
  a_trigger_cause: assert property (trigger_pulse |-> $past(ev_wr && s_axi_wdata[6], 2))
    else $error("trigger pulse without a forcing write");
  a_event_reads_zero: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == tseg_pkg::OFS_EVENT |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
    else $error("event register read not zero");
  a_dma_one_cycle: assert property (dma_req != 4'h0 |=> dma_req == 4'h0)
    else $error("dma request longer than one cycle");
  a_event_write_ok: assert property (ev_wr |-> ##2 s_axi_bvalid &&
    s_axi_bresp == tseg_pkg::RESP_OKAY) else $error("event write not answered okay");
  c_update: cover property (update_pulse);
  c_trigger: cover property (trigger_pulse);
  c_dma: cover property (dma_req != 4'h0);
  c_irq: cover property (irq);
endmodule // tseg_checker

bind tseg_timer tseg_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq), .dma_req(dma_req),
  .update_pulse(update_pulse), .trigger_pulse(trigger_pulse));

/* File: verif/timer_sw_event_generation_tb.sv */
`timescale 1ns/1ps
module timer_sw_event_generation_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, upd, trg;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] dma, dma_seen = 4'h0;
  logic trg_seen = 1'b0;
  int num_errors = 0;
  int n_checks = 0;
  // clock and sticky record of one-cycle pulses
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    if (aresetn) begin
      dma_seen <= dma_seen | dma;
      trg_seen <= trg_seen | trg;
    end
  end
  tseg_timer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq), .dma_req(dma), .update_pulse(upd), .trigger_pulse(trg));
  // verdict and shared comparison
  task automatic give_verdict;
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one write: address and data offered together, response awaited under a bound
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] er = tseg_pkg::RESP_OKAY);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 40 && !bvalid; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (k == 40) begin
      chk(32'h0000_0000, 32'h0000_0001);
      give_verdict();
    end
    chk(32'(bresp), 32'(er));
  endtask
  // one read compared against the expected low half-word
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 40 && !rvalid; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (k == 40) begin
      chk(32'h0000_0000, 32'h0000_0001);
      give_verdict();
    end
    chk(rdata, {16'h0000, e});
    chk(32'(rresp), 32'(tseg_pkg::RESP_OKAY));
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(tseg_pkg::OFS_EVENT, 16'h0000);
    wr(tseg_pkg::OFS_EVENT, 16'hff80);
    rdc(tseg_pkg::OFS_STATUS, 16'h0000);
    wr(8'h80, 16'h0001, tseg_pkg::RESP_SLVERR);
    wr(tseg_pkg::OFS_RELOAD, 16'h1234);
    wr(tseg_pkg::OFS_PSC, 16'h0007);
    // i=0 counts down, i=1 and i=2 center-aligned variants of the mode field
    for (int i = 0; i < 3; i++) begin
      wr(tseg_pkg::OFS_CTRL, {9'h000, 2'(i), 1'(i == 0), 4'h0});
      wr(tseg_pkg::OFS_CNT, 16'h0055);
      wr(tseg_pkg::OFS_EVENT, 16'h0001);
      rdc(tseg_pkg::OFS_CNT, (i == 0) ? 16'h1234 : 16'h0000);
    end
    wr(tseg_pkg::OFS_CTRL, 16'h0000);
    wr(tseg_pkg::OFS_CNT, 16'h0055);
    wr(tseg_pkg::OFS_EVENT, 16'h0001);
    rdc(tseg_pkg::OFS_CNT, 16'h0000);
    rdc(tseg_pkg::OFS_PSC, 16'h0007);
    // running counter: a forced update restarts prescaler and counter together
    wr(tseg_pkg::OFS_PSC, 16'h0003);
    wr(tseg_pkg::OFS_CTRL, 16'h0001);
    wr(tseg_pkg::OFS_EVENT, 16'h0001);
    rdc(tseg_pkg::OFS_CNT, 16'h0000);
    rdc(tseg_pkg::OFS_CNT, 16'h0001);
    wr(tseg_pkg::OFS_CTRL, 16'h0000);
    wr(tseg_pkg::OFS_IRQ_EN, 16'h0001);
    rdc(tseg_pkg::OFS_STATUS, 16'h0001);
    chk(32'(irq), 32'h0000_0001);
    wr(tseg_pkg::OFS_IRQ_EN, 16'h0000);
    rdc(tseg_pkg::OFS_STATUS, 16'h0001);
    chk(32'(irq), 32'h0000_0000);
    wr(tseg_pkg::OFS_IRQ_EN, 16'h1e5f);
    wr(tseg_pkg::OFS_STATUS, 16'h0000);
    rdc(tseg_pkg::OFS_STATUS, 16'h0000);
    chk(32'(irq), 32'h0000_0000);
    // each channel as output, then as input with a repeated capture
    for (int i = 0; i < 4; i++) begin
      wr(tseg_pkg::OFS_EVENT, 16'(2 << i));
      rdc(tseg_pkg::OFS_STATUS, 16'(2 << i));
      chk(32'(irq), 32'h0000_0001);
      wr(tseg_pkg::OFS_STATUS, 16'h0000);
    end
    chk(32'(dma_seen), 32'h0000_000f);
    for (int i = 0; i < 4; i++) begin
      wr(tseg_pkg::OFS_CTRL, 16'(16'h0100 << i));
      wr(tseg_pkg::OFS_CNT, 16'h0100 + 16'(i));
      wr(tseg_pkg::OFS_EVENT, 16'(2 << i));
      wr(tseg_pkg::OFS_EVENT, 16'(2 << i));
      rdc(tseg_pkg::OFS_CAP1 + 8'(4 * i), 16'h0100 + 16'(i));
      rdc(tseg_pkg::OFS_STATUS, 16'((2 << i) | (16'h0200 << i)));
      wr(tseg_pkg::OFS_STATUS, 16'h0000);
    end
    chk(32'(trg_seen), 32'h0000_0000);
    wr(tseg_pkg::OFS_EVENT, 16'h0040);
    rdc(tseg_pkg::OFS_STATUS, 16'h0040);
    chk(32'(irq), 32'h0000_0001);
    chk(32'(trg_seen), 32'h0000_0001);
    rdc(tseg_pkg::OFS_EVENT, 16'h0000);
    give_verdict();
  end
endmodule // timer_sw_event_generation_tb
